//--- verilog/speed_clock_ctrl.sv
// Purpose: Bus speed settlement, secondary clock generation and gating
// Assumes: Primary clock is clk; straps synchronous; classic Wishbone slave
// Notes:   Secondary clocks are registered copies of a divided or toggled clock
//
// Overview of operation
// - With the clock-control strap high and D3 set, the secondary bus enters B2.
// - Entering B2 stops every secondary clock and holds it at 0.
// - With the clock-control strap low, D3 leaves secondary clocks running.
// - A low 66 MHz strap limits both interfaces to 33 MHz and clears the capable flag.
// - A high 66 MHz strap makes the device report itself fast capable.
// - A low primary speed indication pulls the secondary speed pin low.
// - The secondary speed pin is open drain, never driven high.
// - In hot-swap mode general pin three feeds the ejector handle input.
// - Fast primary with slow secondary divides the primary clock by four.
`timescale 1ns/1ps
module speed_clock_ctrl #(
    parameter int num_sclk   = spd_pkg::num_sclk,
    parameter int gpio_width = spd_pkg::gpio_width
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_we_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    output logic                       wb_ack_o,
    input  wire logic                  bus_power_clock_ctrl_strap,
    input  wire logic                  fast_capable_strap,
    input  wire logic                  primary_speed_ind,
    input  wire logic                  secondary_speed_ind_i,
    output logic                       secondary_speed_ind_o,
    output logic                       secondary_speed_ind_oe,
    input  wire logic [gpio_width-1:0] general_pin_i,
    output logic [num_sclk-1:0]        sec_clk_out,
    output logic                       fast_capable,
    output logic                       ejector_handle_input,
    output logic                       bus_b2_state
);
    spd_pkg::strap_t straps;
    spd_pkg::cfg_t   cfg;
    logic [1:0]  ctrl_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic        div_r;
    logic [num_sclk-1:0] sclk_r;

    assign straps = '{bus_power_clock_ctrl_strap, fast_capable_strap,
                      primary_speed_ind, secondary_speed_ind_i};

    strap_latch u_latch (
        .clk    (clk),
        .sys_rst(sys_rst),
        .ce     (ce),
        .straps (straps),
        .cfg    (cfg)
    );

    wire d3_req   = ctrl_r[spd_pkg::ctrl_d3_bit];
    wire hs_mode  = ctrl_r[spd_pkg::ctrl_hs_bit];
    wire b2_state = cfg.clock_gating_ok & d3_req;
    wire div_mode = cfg.prim_fast & ~cfg.sec_fast;

    // Bus decode
    wire req      = wb_cyc_i & wb_stb_i & ~ack_r;
    wire hit_ctrl = wb_adr_i == spd_pkg::ctrl_off;
    wire hit_stat = wb_adr_i == spd_pkg::stat_off;
    wire hit_gpio = wb_adr_i == spd_pkg::gpio_off;
    wire wr_ctrl  = req & wb_we_i & hit_ctrl & wb_sel_i[0];
    wire [31:0] stat_word = {26'h0, b2_state, div_mode, cfg.clock_gating_ok,
                             cfg.sec_fast, cfg.prim_fast, cfg.fast_capable};
    wire [31:0] gpio_word = {{(32-gpio_width){1'b0}}, general_pin_i};
    wire [31:0] rd_word   = hit_ctrl ? {30'h0, ctrl_r} :
                            hit_stat ? stat_word :
                            hit_gpio ? gpio_word : spd_pkg::unmapped_value;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= spd_pkg::ctrl_reset;
            ack_r  <= 1'b0;
            dat_r  <= 32'h0;
        end else if (ce) begin
            ack_r <= req;
            dat_r <= rd_word;
            if (wr_ctrl) begin
                ctrl_r <= wb_dat_i[1:0];
            end
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Secondary clocks: full rate follows clk-derived toggle, half rate toggles every other edge
    logic div2_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_r  <= 1'b0;
            div2_r <= 1'b0;
            sclk_r <= '0;
        end else if (ce) begin
            div_r <= ~div_r;
            if (div_r) begin
                div2_r <= ~div2_r;
            end
            if (b2_state) begin
                sclk_r <= '0;
            end else begin
                sclk_r <= {num_sclk{div_mode ? div2_r : div_r}};
            end
        end
    end
    assign sec_clk_out = sclk_r;

    // Open drain: output is constant low, only enable moves
    assign secondary_speed_ind_o  = 1'b0;
    assign secondary_speed_ind_oe = ~sys_rst & ~cfg.prim_fast;
    assign fast_capable           = cfg.fast_capable;
    assign ejector_handle_input   = hs_mode & general_pin_i[spd_pkg::gpio_hs_index];
    assign bus_b2_state           = b2_state;

    // Each step samples reset and ce itself, so no window opens on the release edge
    sequence half_run_s;
        ce && !sys_rst && div_mode && !b2_state;
    endsequence

    sequence full_run_s;
        ce && !sys_rst && !div_mode && !b2_state;
    endsequence

    sequence wb_take_s;
        ce && !sys_rst && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence ctrl_write_s;
        wb_take_s ##0 (wb_we_i && wb_adr_i == spd_pkg::ctrl_off && wb_sel_i[0]);
    endsequence

    sequence ctrl_read_s;
        wb_take_s ##0 (!wb_we_i && wb_adr_i == spd_pkg::ctrl_off);
    endsequence

    sequence strap_take_s;
        ce && sys_rst;
    endsequence

    gate_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && b2_state |=> sec_clk_out == '0)
        else $error("secondary clocks not stopped in b2");

    no_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.clock_gating_ok |-> !bus_b2_state)
        else $error("b2 entered with gating strap low");

    enter_b2_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.clock_gating_ok && d3_req |-> bus_b2_state)
        else $error("b2 not entered in d3");

    full_run_a: assert property (@(posedge clk) disable iff (sys_rst)
        full_run_s ##1 full_run_s ##1 full_run_s
        |-> sec_clk_out[0] != $past(sec_clk_out[0]))
        else $error("full rate clock not toggling");

    slow_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.fast_capable |-> !cfg.prim_fast && !cfg.sec_fast && !fast_capable)
        else $error("fast mode without strap");

    fast_cap_a: assert property (@(posedge clk)
        strap_take_s |=> fast_capable == $past(fast_capable_strap))
        else $error("capable flag does not follow strap");

    prim_take_a: assert property (@(posedge clk)
        strap_take_s |=> cfg.prim_fast ==
            ($past(fast_capable_strap) && $past(primary_speed_ind)))
        else $error("primary speed not captured in reset");

    sec_take_a: assert property (@(posedge clk)
        strap_take_s |=> cfg.sec_fast ==
            ($past(fast_capable_strap) && $past(primary_speed_ind)
             && $past(secondary_speed_ind_i)))
        else $error("secondary speed not read from pin");

    speed_keep_a: assert property (@(posedge clk)
        !sys_rst && !$past(sys_rst)
        |-> $stable(fast_capable) && $stable(secondary_speed_ind_oe))
        else $error("speed configuration changed outside reset");

    pull_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && !cfg.prim_fast |-> secondary_speed_ind_oe)
        else $error("secondary speed not pulled low");

    drive_free_a: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst && cfg.prim_fast |-> !secondary_speed_ind_oe)
        else $error("speed pin held low with fast primary");

    open_drain_a: assert property (@(posedge clk)
        !secondary_speed_ind_o)
        else $error("speed pin driven high");

    half_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(ce) && !$past(sys_rst) |-> div_r != $past(div_r))
        else $error("divider phase");

    div_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
        half_run_s ##1 half_run_s ##1 half_run_s ##1 half_run_s
        |-> sec_clk_out[0] != $past(sec_clk_out[0], 2))
        else $error("half rate clock not toggling");

    hs_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        ejector_handle_input ==
            (hs_mode && general_pin_i[spd_pkg::gpio_hs_index]))
        else $error("ejector input mismatch");

    ack_after_a: assert property (@(posedge clk) disable iff (sys_rst)
        wb_take_s |=> wb_ack_o)
        else $error("bus request not acknowledged");

    ack_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !sys_rst && wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held past one cycle");

    ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_write_s |=> ctrl_r == $past(wb_dat_i[1:0]))
        else $error("control write lost");

    ctrl_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_read_s |=> wb_dat_o == {30'h0, $past(ctrl_r)})
        else $error("control read data wrong");
endmodule

//--- verilog/spd_pkg.sv
// Purpose: Shared constants and carrier types for bus speed and clock gating
// Assumes: 125 MHz core clock, Wishbone register access
// Notes:   Offsets are byte addresses of 32-bit words
package spd_pkg;
    localparam logic [3:0] ctrl_off        = 4'h0;
    localparam logic [3:0] stat_off        = 4'h4;
    localparam logic [3:0] gpio_off        = 4'h8;
    localparam int         ctrl_d3_bit     = 0;
    localparam int         ctrl_hs_bit     = 1;
    localparam logic [1:0] ctrl_reset      = 2'h0;
    localparam int         num_sclk        = 10;
    localparam int         gpio_width      = 4;
    localparam int         gpio_hs_index   = 3;
    localparam logic [31:0] unmapped_value = 32'h0;

    typedef struct packed {
        logic bus_power_clock_ctrl_strap;
        logic fast_capable_strap;
        logic primary_speed_ind;
        logic secondary_speed_ind;
    } strap_t;

    typedef struct packed {
        logic fast_capable;
        logic sec_fast;
        logic prim_fast;
        logic clock_gating_ok;
    } cfg_t;
endpackage

//--- verilog/strap_latch.sv
// Purpose: Captures straps during reset and holds them until next reset
// Assumes: Straps synchronous to clk
// Notes:   Registered output, stable outside reset
`timescale 1ns/1ps
module strap_latch (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          ce,
    input  wire spd_pkg::strap_t straps,
    output spd_pkg::cfg_t      cfg
);
    spd_pkg::cfg_t cfg_r;
    spd_pkg::cfg_t cfg_nxt;
    wire fast_ok = straps.fast_capable_strap;
    wire prim_ok = fast_ok & straps.primary_speed_ind;

    always_comb begin
        cfg_nxt.fast_capable    = fast_ok;
        cfg_nxt.prim_fast       = prim_ok;
        cfg_nxt.sec_fast        = prim_ok & straps.secondary_speed_ind;
        cfg_nxt.clock_gating_ok = straps.bus_power_clock_ctrl_strap;
    end

    // Sampling only under reset keeps clock rates from changing mid-operation
    always_ff @(posedge clk) begin
        if (ce && sys_rst) begin
            cfg_r <= cfg_nxt;
        end
    end
    assign cfg = cfg_r;

    hold_stable_a: assert property (@(posedge clk)
        !sys_rst && !$past(sys_rst) |-> $stable(cfg_r))
        else $error("strap config changed outside reset");
endmodule

//--- sim/board_model.sv
// Purpose: Board straps and the pull resistor on the secondary speed pin
// Assumes: One board resistor on the open-drain pin
// Notes:   The pin shows the pull level whenever the bridge lets go
`timescale 1ns/1ps
module board_model (
    input  wire logic [3:1]      set_straps,
    input  wire logic            pull_high,
    input  wire logic            sink_oe,
    output spd_pkg::strap_t      straps,
    output logic                 pin_level
);
    // Board resistor decides the level unless the bridge sinks it
    assign pin_level = sink_oe ? 1'b0 : pull_high;
    assign straps    = {set_straps, pin_level};
endmodule

//--- sim/bus_speed_and_clock_gating_tb_top.sv
// Purpose: Strap settlement, clock gating and hot-swap pin checks
// Assumes: ce held high; straps may change outside reset but take effect only at a new reset
// Notes:   Clock activity is judged by edges of secondary clock 0
`timescale 1ns/1ps
module bus_speed_and_clock_gating_tb_top;
    logic            clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pull = 1'b1;
    logic [3:0]      adr = 4'h0, gp = 4'h0;
    logic [3:1]      sset = 3'h0;
    logic [31:0]     wdat = 32'h0, q, dat_o;
    logic [9:0]      sclk;
    logic            ack, sdo, oe, fc, ej, b2, pin;
    spd_pkg::strap_t st_w;
    int              n_mismatch = 0, checks_done = 0;
    initial forever #4 clk = ~clk;
    board_model brd (.set_straps(sset), .pull_high(pull), .sink_oe(oe), .straps(st_w),
                     .pin_level(pin));
    speed_clock_ctrl dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack),
        .bus_power_clock_ctrl_strap(st_w.bus_power_clock_ctrl_strap),
        .fast_capable_strap(st_w.fast_capable_strap), .primary_speed_ind(st_w.primary_speed_ind),
        .secondary_speed_ind_i(pin), .secondary_speed_ind_o(sdo), .secondary_speed_ind_oe(oe),
        .general_pin_i(gp), .sec_clk_out(sclk), .fast_capable(fc), .ejector_handle_input(ej),
        .bus_b2_state(b2));
    task automatic test_done();
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            test_done();
        end
    endtask
    task automatic boot(input logic [3:1] s, input logic p);
        @(posedge clk);
        sset <= s; pull <= p; sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
    endtask
    // Expected status word from strap levels, as the bridge should settle them
    function automatic logic [31:0] stx(logic g, f, p, s, bb);
        logic pf;
        pf = f & p;
        return {26'h0, bb, pf & ~(pf & s), g, pf & s, pf, f};
    endfunction
    task automatic edges(input int e);
        int n;
        logic prv;
        n = 0;
        prv = sclk[0];
        repeat (16) begin
            @(posedge clk);
            if (sclk[0] !== prv) n++;
            prv = sclk[0];
        end
        chk(n, e);
    endtask
    initial begin
        boot(3'h7, 1'b1);
        wb(4'h4, 1'b0, 32'h0); chk(q, stx(1, 1, 1, 1, 0));
        chk(32'(oe), 32'h0); chk(32'(fc), 32'h1); edges(16);
        sset <= 3'h0; pull <= 1'b0;
        wb(4'h4, 1'b0, 32'h0); chk(q, stx(1, 1, 1, 1, 0));
        wb(4'h0, 1'b1, 32'h1); wb(4'h4, 1'b0, 32'h0); chk(q, stx(1, 1, 1, 1, 1));
        chk(32'(b2), 32'h1); edges(0); chk(32'(sclk), 32'h0);
        boot(3'h3, 1'b0);
        wb(4'h4, 1'b0, 32'h0); chk(q, stx(0, 1, 1, 0, 0)); edges(8);
        wb(4'h0, 1'b1, 32'h1); edges(8); chk(32'(b2), 32'h0);
        boot(3'h5, 1'b1);
        wb(4'h4, 1'b0, 32'h0); chk(q, stx(1, 0, 1, 1, 0)); chk(32'(fc), 32'h0);
        chk(32'(oe), 32'h1); chk(32'(sdo), 32'h0); edges(16);
        boot(3'h6, 1'b1);
        wb(4'h4, 1'b0, 32'h0); chk(q, stx(1, 1, 0, 0, 0)); chk(32'(oe), 32'h1);
        chk(32'(pin), 32'h0);
        wb(4'h0, 1'b1, 32'h2); gp <= 4'h8; @(posedge clk);
        @(posedge clk); chk(32'(ej), 32'h1);
        wb(4'h8, 1'b0, 32'h0); chk(q, 32'h8); gp <= 4'h7; @(posedge clk);
        @(posedge clk); chk(32'(ej), 32'h0);
        wb(4'h0, 1'b1, 32'h0); gp <= 4'h8; @(posedge clk);
        @(posedge clk); chk(32'(ej), 32'h0);
        wb(4'hc, 1'b0, 32'h0); chk(q, spd_pkg::unmapped_value);
        test_done();
    end
endmodule
